// file: shared/arwc_pkg.sv
// package: register map, field layout, reset values and modes of the result/window block
package arwc_pkg;
    // ************************************************************
    // register offsets (byte addresses on the cpu register port)
    // ************************************************************
    localparam logic [7:0] OFS_DEBUG_CTRL   = 8'h0C;
    localparam logic [7:0] OFS_STAGING      = 8'h0D;
    localparam logic [7:0] OFS_RESULT       = 8'h10;
    localparam logic [7:0] OFS_WIN_LOW      = 8'h12;
    localparam logic [7:0] OFS_WIN_HIGH     = 8'h14;
    localparam logic [7:0] OFS_DUTY_CLOCK_DUTY_CALIBRATION   = 8'h16;
    localparam logic [7:0] OFS_FLAGS        = 8'h0B;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int         BIT_KEEP_RUNNING = 0;
    localparam int         BIT_DUTY_SELECT  = 0;
    localparam int         BIT_READY_FLAG   = 0;
    localparam int         BIT_MATCH_FLAG   = 1;
    localparam logic [7:0] RST_STAGING      = 8'h00;
    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [7:0] RST_DEBUG_CTRL   = 8'h00;
    localparam logic [7:0] RST_DUTY_CLOCK_DUTY_CALIBRATION   = 8'h01;

    // ************************************************************
    // converter format
    // ************************************************************
    localparam int          RAW_WIDTH       = 10;
    localparam logic [9:0]  RAW_MAX         = 10'h3FF;
    localparam logic [9:0]  RAW_MIN         = 10'h000;
    localparam int          MAX_ACCUM       = 64;
    localparam logic [15:0] ACCUM_CEILING   = 16'hFFC0;

    // ************************************************************
    // converter clock divider: one period of four peripheral clocks
    // ************************************************************
    localparam logic [1:0]  DIV_LAST        = 2'h3;
    localparam logic [1:0]  DIV_HALF        = 2'h2;
    localparam logic [1:0]  DIV_QUARTER     = 2'h1;

    typedef enum logic [2:0] {
        ARWC_WIN_NONE    = 3'h0,
        ARWC_WIN_BELOW   = 3'h1,
        ARWC_WIN_ABOVE   = 3'h2,
        ARWC_WIN_INSIDE  = 3'h3,
        ARWC_WIN_OUTSIDE = 3'h4
    } arwc_win_mode_t;
endpackage

// file: shared/arwc_cmp_if.sv
// interface: result and thresholds handed to the window comparator
`timescale 1ns/1ps
interface arwc_cmp_if;
    logic [15:0] result;
    logic [15:0] low;
    logic [15:0] high;
    logic [2:0]  mode;
    logic        match;
    modport ctrl (output result, output low, output high, output mode, input match);
    modport cmp  (input result, input low, input high, input mode, output match);
endinterface

// file: verilog/arwc_window_cmp.sv
// window comparator: unsigned compare of a result against the low threshold, the high threshold or both, by mode
`timescale 1ns/1ps
module arwc_window_cmp (
    arwc_cmp_if.cmp bus
);
    always_comb begin
        case (bus.mode)
            arwc_pkg::ARWC_WIN_BELOW:   bus.match = bus.result < bus.low;
            arwc_pkg::ARWC_WIN_ABOVE:   bus.match = bus.result > bus.high;
            arwc_pkg::ARWC_WIN_INSIDE:  bus.match = (bus.result > bus.low) &&
                                                    (bus.result < bus.high);
            arwc_pkg::ARWC_WIN_OUTSIDE: bus.match = (bus.result < bus.low) ||
                                                    (bus.result > bus.high);
            // none and reserved codes never match
            default:                    bus.match = 1'b0;
        endcase
    end
endmodule

// file: verilog/arwc_duty_clock.sv
// converter clock generator: divide by four, 25 or 50 percent high time
`timescale 1ns/1ps
module arwc_duty_clock (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic run,
    input  wire logic quarter_duty,
    output logic      conv_clk
);
    typedef struct packed {
        logic [1:0] phase;
        logic       clk;
    } arwc_div_t;

    arwc_div_t state;
    arwc_div_t next_state;

    always_comb begin
        next_state = state;
        if (run) begin
            next_state.phase = state.phase + 2'h1;
        end
        // high for one of four phases or for two of four
        if (quarter_duty) begin
            next_state.clk = next_state.phase < arwc_pkg::DIV_QUARTER;
        end else begin
            next_state.clk = next_state.phase < arwc_pkg::DIV_HALF;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign conv_clk = state.clk;

    // high only in phase zero of four; a halt or a duty change cannot trip it
    a_duty_quarter_high: assert property (@(posedge ref_clk) disable iff (!resetn)
        (state.clk && $past(quarter_duty)) |-> state.phase == 2'h0)
        else $error("quarter duty clock high outside its phase");
endmodule

// file: verilog/arwc_result_regs.sv
// result, staging, thresholds, duty calibration and debug run registers of the converter
`timescale 1ns/1ps
module arwc_result_regs #(
    parameter int ACCUM_MAX = arwc_pkg::MAX_ACCUM
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata,
    input  wire logic       cpu_halted,
    input  wire logic       start_event,
    input  wire logic       sample_valid,
    input  wire logic [9:0] sample_code,
    input  wire logic       sample_over,
    input  wire logic       sample_under,
    input  wire logic [6:0] accum_count,
    input  wire logic [2:0] window_mode_select,
    output logic            converter_run,
    output logic            event_accepted,
    output logic            conv_clk,
    output logic            result_ready_flag,
    output logic            window_match_flag
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0]  staging;
        logic [15:0] result;
        logic [15:0] low;
        logic [15:0] high;
        logic        keep_running;
        logic        duty_select;
        logic [15:0] accum;
        logic [6:0]  taken;
        logic        ready;
        logic        match;
        logic [7:0]  rdata;
    } arwc_regs_t;

    arwc_regs_t state;
    arwc_regs_t next_state;

    arwc_cmp_if cmp ();

    logic        run;
    logic [9:0]  clamped;
    logic [15:0] sum;
    logic        last_sample;
    logic        done;
    logic [7:0]  base;
    logic        high_half;

    // word base of a 16-bit register, or 0 when the address is not one
    function automatic logic [7:0] word_base(input logic [7:0] a);
        logic [7:0] b;
        b = {a[7:1], 1'b0};
        if (b == arwc_pkg::OFS_RESULT || b == arwc_pkg::OFS_WIN_LOW ||
            b == arwc_pkg::OFS_WIN_HIGH) begin
            return b;
        end
        return 8'h00;
    endfunction

    // ************************************************************
    // conversion datapath
    // ************************************************************
    assign run = state.keep_running || !cpu_halted;

    always_comb begin
        if (sample_over) begin
            clamped = arwc_pkg::RAW_MAX;
        end else if (sample_under) begin
            clamped = arwc_pkg::RAW_MIN;
        end else begin
            clamped = sample_code;
        end
    end

    // 64 x 0x3FF fits in 16 bits, so no carry is lost
    assign sum = state.accum + {6'h00, clamped};
    assign last_sample = (state.taken + 7'h01 >= accum_count) ||
                         (state.taken + 7'h01 >= 7'(ACCUM_MAX));
    assign done = run && sample_valid && last_sample;

    assign cmp.result = sum;
    assign cmp.low    = state.low;
    assign cmp.high   = state.high;
    assign cmp.mode   = window_mode_select;

    arwc_window_cmp u_cmp (
        .bus (cmp)
    );

    arwc_duty_clock u_clk (
        .ref_clk      (ref_clk),
        .resetn       (resetn),
        .run          (run),
        .quarter_duty (state.duty_select),
        .conv_clk     (conv_clk)
    );

    assign base      = word_base(reg_addr);
    assign high_half = reg_addr[0];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_state = state;
        // register reads: low half latches the high half in staging
        next_state.rdata = 8'h00;
        if (reg_read) begin
            if (reg_addr == arwc_pkg::OFS_STAGING) begin
                next_state.rdata = state.staging;
            end else if (reg_addr == arwc_pkg::OFS_DEBUG_CTRL) begin
                next_state.rdata = {7'h00, state.keep_running};
            end else if (reg_addr == arwc_pkg::OFS_DUTY_CLOCK_DUTY_CALIBRATION) begin
                next_state.rdata = {7'h00, state.duty_select};
            end else if (reg_addr == arwc_pkg::OFS_FLAGS) begin
                next_state.rdata = {6'h00, state.match, state.ready};
            end else if (base != 8'h00 && !high_half) begin
                if (base == arwc_pkg::OFS_RESULT) begin
                    next_state.rdata   = state.result[7:0];
                    next_state.staging = state.result[15:8];
                end else if (base == arwc_pkg::OFS_WIN_LOW) begin
                    next_state.rdata   = state.low[7:0];
                    next_state.staging = state.low[15:8];
                end else begin
                    next_state.rdata   = state.high[7:0];
                    next_state.staging = state.high[15:8];
                end
            end else if (base != 8'h00) begin
                next_state.rdata = state.staging;
            end
        end
        // register writes
        if (reg_write) begin
            if (reg_addr == arwc_pkg::OFS_STAGING) begin
                next_state.staging = reg_wdata;
            end else if (reg_addr == arwc_pkg::OFS_DEBUG_CTRL) begin
                next_state.keep_running = reg_wdata[arwc_pkg::BIT_KEEP_RUNNING];
            end else if (reg_addr == arwc_pkg::OFS_DUTY_CLOCK_DUTY_CALIBRATION) begin
                next_state.duty_select = reg_wdata[arwc_pkg::BIT_DUTY_SELECT];
            end else if (base == arwc_pkg::OFS_WIN_LOW || base == arwc_pkg::OFS_WIN_HIGH) begin
                if (!high_half) begin
                    next_state.staging = reg_wdata;
                end else if (base == arwc_pkg::OFS_WIN_LOW) begin
                    next_state.low  = {reg_wdata, state.staging};
                end else begin
                    next_state.high = {reg_wdata, state.staging};
                end
            end
        end
        // flag clears: write one or read result; a same-cycle set wins below
        if (reg_write && reg_addr == arwc_pkg::OFS_FLAGS) begin
            if (reg_wdata[arwc_pkg::BIT_READY_FLAG]) begin
                next_state.ready = 1'b0;
            end
            if (reg_wdata[arwc_pkg::BIT_MATCH_FLAG]) begin
                next_state.match = 1'b0;
            end
        end
        if (reg_read && base == arwc_pkg::OFS_RESULT) begin
            next_state.ready = 1'b0;
            next_state.match = 1'b0;
        end
        // samples are ignored while halted in debug, unless keep running is set
        if (run && sample_valid) begin
            if (last_sample) begin
                next_state.result = sum;
                next_state.accum  = arwc_pkg::RST_WORD;
                next_state.taken  = 7'h00;
                next_state.ready  = 1'b1;
                if (cmp.match) begin
                    next_state.match = 1'b1;
                end
            end else begin
                next_state.accum = sum;
                next_state.taken = state.taken + 7'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state              <= '0;
            state.staging      <= arwc_pkg::RST_STAGING;
            state.result       <= arwc_pkg::RST_WORD;
            state.low          <= arwc_pkg::RST_WORD;
            state.high         <= arwc_pkg::RST_WORD;
            state.keep_running <= arwc_pkg::RST_DEBUG_CTRL[0];
            state.duty_select  <= arwc_pkg::RST_DUTY_CLOCK_DUTY_CALIBRATION[0];
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata         = state.rdata;
    assign converter_run     = run;
    assign event_accepted    = run && start_event;
    assign result_ready_flag = state.ready;
    assign window_match_flag = state.match;

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_final_sample;
        run && sample_valid && last_sample;
    endsequence

    a_halt_drops_event: assert property (@(posedge ref_clk) disable iff (!resetn)
        (cpu_halted && !state.keep_running) |-> !event_accepted && !converter_run)
        else $error("event accepted while halted");
    a_debug_keeps_run: assert property (@(posedge ref_clk) disable iff (!resetn)
        state.keep_running |-> converter_run)
        else $error("converter stopped with keep running set");
    a_result_latched: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_final_sample |=> state.result == $past(sum) && result_ready_flag)
        else $error("result not latched at conversion end");
    a_over_saturates: assert property (@(posedge ref_clk) disable iff (!resetn)
        sample_over |-> clamped == 10'h3FF)
        else $error("over-range not saturated");
    a_under_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        (sample_under && !sample_over) |-> clamped == 10'h000)
        else $error("under-range not zero");
    a_accum_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
        state.accum <= 16'hFFC0)
        else $error("accumulator beyond ceiling");
    a_match_only_end: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(window_match_flag) |-> $past(done) && $past(cmp.match))
        else $error("match flag set outside conversion end");
    a_result_read_clr: assert property (@(posedge ref_clk) disable iff (!resetn)
        (reg_read && base == arwc_pkg::OFS_RESULT && !done) |=> !result_ready_flag)
        else $error("ready flag survived result read");
    a_staged_commit: assert property (@(posedge ref_clk) disable iff (!resetn)
        (reg_write && reg_addr == 8'h13) |=> state.low == {$past(reg_wdata), $past(state.staging)})
        else $error("low threshold not committed as a word");
    a_reserved_mode_quiet: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_final_sample && window_mode_select > 3'h4) |-> !cmp.match)
        else $error("reserved window mode produced a match");
    a_rdata_idle_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
        !reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero without a read");
endmodule

// file: dv/test_adc_result_window_compare.sv
// testbench: registers, conversions, window modes, debug run and converter clock duty
`timescale 1ns/1ps
module test_adc_result_window_compare;
    logic        ref_clk;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [7:0]  reg_rdata;
    logic        cpu_halted;
    logic        start_event;
    logic        sample_valid;
    logic [9:0]  sample_code;
    logic        sample_over;
    logic        sample_under;
    logic [6:0]  accum_count;
    logic [2:0]  window_mode_select;
    logic        converter_run;
    logic        event_accepted;
    logic        conv_clk;
    logic        result_ready_flag;
    logic        window_match_flag;
    int          n_mismatch;
    int          check_count;
    int          cycles;
    logic [31:0] seed;
    logic [15:0] win_lo;
    logic [15:0] win_hi;
    logic [15:0] sum;
    logic [15:0] word;
    logic [7:0]  byte_seen;
    int          highs;
    int          toggles;

    arwc_result_regs #(
        .ACCUM_MAX          (arwc_pkg::MAX_ACCUM)
    ) u_arwc_result_regs (
        .ref_clk            (ref_clk),
        .resetn             (resetn),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_write          (reg_write),
        .reg_read           (reg_read),
        .reg_rdata          (reg_rdata),
        .cpu_halted         (cpu_halted),
        .start_event        (start_event),
        .sample_valid       (sample_valid),
        .sample_code        (sample_code),
        .sample_over        (sample_over),
        .sample_under       (sample_under),
        .accum_count        (accum_count),
        .window_mode_select (window_mode_select),
        .converter_run      (converter_run),
        .event_accepted     (event_accepted),
        .conv_clk           (conv_clk),
        .result_ready_flag  (result_ready_flag),
        .window_match_flag  (window_match_flag)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic exp_match(input logic [2:0] m, input logic [15:0] r);
        case (m)
            3'h1: return r < win_lo;
            3'h2: return r > win_hi;
            3'h3: return (r > win_lo) && (r < win_hi);
            3'h4: return (r < win_lo) || (r > win_hi);
            default: return 1'b0;
        endcase
    endfunction

    // one byte per strobe; read data lands with the edge that takes the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        // let the edge that took the write settle before anyone looks
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] w);
        wr(a, w[7:0]);
        wr(a + 8'h01, w[15:8]);
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] w);
        rd(a, w[7:0]);
        rd(a + 8'h01, w[15:8]);
    endtask

    // n samples back to back; expected sum built from the saturation rules
    task automatic conv(input int n, input logic ov, input logic un);
        logic [9:0] c;
        sum = 16'h0000;
        wr(arwc_pkg::OFS_FLAGS, 8'h03);
        accum_count <= n[6:0];
        // a count of 0 still means one single conversion
        for (int i = 0; i < n || i == 0; i++) begin
            @(posedge ref_clk);
            c = rnd();
            sample_valid <= 1'b1;
            sample_code <= c;
            sample_over <= ov;
            sample_under <= un;
            sum = sum + {6'h00, ov ? 10'h3FF : (un ? 10'h000 : c)};
        end
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        #1;
    endtask

    task automatic duty(output int h, output int t);
        logic last;
        h = 0;
        t = 0;
        last = conv_clk;
        repeat (8) begin
            @(posedge ref_clk);
            #1;
            h += conv_clk;
            t += (conv_clk !== last);
            last = conv_clk;
        end
    endtask

    // ************************************************************
    // clock, reset, timeout
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [7:0] addrs [10];
        logic [7:0] rstv [10];
        addrs = '{8'h0D, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h0C, 8'h20};
        rstv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
        {reg_addr, reg_wdata, reg_write, reg_read, cpu_halted, start_event} = '0;
        {sample_valid, sample_code, sample_over, sample_under} = '0;
        accum_count = 7'h01;
        window_mode_select = 3'h0;
        resetn = 1'b0;
        n_mismatch = 0;
        check_count = 0;
        cycles = 0;
        seed = 32'h0000003E;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(addrs[i], byte_seen);
            check("reset value", {8'h00, byte_seen}, {8'h00, rstv[i]});
        end
        wr(arwc_pkg::OFS_STAGING, 8'hA5);
        rd(arwc_pkg::OFS_STAGING, byte_seen);
        check("staging rw", {8'h00, byte_seen}, 16'h00A5);
        wr16(arwc_pkg::OFS_RESULT, 16'hFFFF);
        rd16(arwc_pkg::OFS_RESULT, word);
        check("result read only", word, 16'h0000);
        wr(8'h20, 8'h55);
        rd(8'h20, byte_seen);
        check("unmapped", {8'h00, byte_seen}, 16'h0000);
        repeat (3) begin
            win_lo = rnd();
            win_hi = rnd();
            wr16(arwc_pkg::OFS_WIN_LOW, win_lo);
            wr16(arwc_pkg::OFS_WIN_HIGH, win_hi);
            rd16(arwc_pkg::OFS_WIN_LOW, word);
            check("low threshold", word, win_lo);
            rd16(arwc_pkg::OFS_WIN_HIGH, word);
            check("high threshold", word, win_hi);
            rd(arwc_pkg::OFS_WIN_HIGH, byte_seen);
            rd(arwc_pkg::OFS_STAGING, byte_seen);
            check("staged high byte", {8'h00, byte_seen}, {8'h00, win_hi[15:8]});
        end
        // second pair puts both thresholds on the saturated code to probe strictness
        for (int p = 0; p < 2; p++) begin
            win_lo = p ? 16'h03FF : 16'h0100;
            win_hi = p ? 16'h03FF : 16'h0300;
            wr16(arwc_pkg::OFS_WIN_LOW, win_lo);
            wr16(arwc_pkg::OFS_WIN_HIGH, win_hi);
            for (int m = 0; m < 8; m++) begin
                window_mode_select <= m[2:0];
                for (int i = 0; i < 4; i++) begin
                    conv(i % 2, i == 1, i == 2);
                    check("ready", result_ready_flag, 1'b1);
                    check("match", window_match_flag, exp_match(m[2:0], sum));
                    rd16(arwc_pkg::OFS_RESULT, word);
                    check("result", word, sum);
                    check("flags after read", {result_ready_flag, window_match_flag}, 0);
                end
            end
        end
        win_lo = 16'h0400;
        win_hi = 16'h03FF;
        wr16(arwc_pkg::OFS_WIN_LOW, win_lo);
        wr16(arwc_pkg::OFS_WIN_HIGH, win_hi);
        window_mode_select <= 3'h1;
        conv(16, 1'b0, 1'b0);
        check("sum match", window_match_flag, exp_match(3'h1, sum));
        window_mode_select <= 3'h2;
        conv(arwc_pkg::MAX_ACCUM, 1'b1, 1'b0);
        rd(arwc_pkg::OFS_FLAGS, byte_seen);
        check("flags reg", {8'h00, byte_seen}, 16'h0003);
        wr(arwc_pkg::OFS_FLAGS, 8'h00);
        check("write zero", {result_ready_flag, window_match_flag}, 2'h3);
        wr(arwc_pkg::OFS_FLAGS, 8'h01);
        check("clear ready", {result_ready_flag, window_match_flag}, 2'h1);
        wr(arwc_pkg::OFS_FLAGS, 8'h02);
        check("clear match", {result_ready_flag, window_match_flag}, 2'h0);
        rd16(arwc_pkg::OFS_RESULT, word);
        check("full accumulation", word, arwc_pkg::ACCUM_CEILING);
        @(posedge ref_clk);
        cpu_halted <= 1'b1;
        start_event <= 1'b1;
        @(posedge ref_clk);
        #1;
        check("halted run", {converter_run, event_accepted}, 2'h0);
        duty(highs, toggles);
        check("clock stopped", toggles, 0);
        conv(1, 1'b0, 1'b0);
        check("sample ignored", result_ready_flag, 1'b0);
        wr(arwc_pkg::OFS_DEBUG_CTRL, 8'h01);
        #1;
        check("debug run", {converter_run, event_accepted}, 2'h3);
        conv(1, 1'b0, 1'b0);
        check("sample in debug", result_ready_flag, 1'b1);
        duty(highs, toggles);
        check("quarter duty", highs, 2);
        wr(arwc_pkg::OFS_DUTY_CLOCK_DUTY_CALIBRATION, 8'h00);
        repeat (4) @(posedge ref_clk);
        duty(highs, toggles);
        check("half duty", highs, 4);
        stop_test();
    end
endmodule
